// ===== rtl/rdr_device.sv
/*
 * rdr_device: serial word capture and refresh sequencer of an
 * 18-channel programmable reference. Serial shifting runs on the
 * link's serial clock; refresh logic runs on clk_i.
 * Assumes serial clock stopped while frame enable is high, and the
 * thermal comparators deliver hot/cool levels asynchronously.
 */
// Function
// - word: zero control bit, index, code
// - code is unsigned fraction of 1024
// - eighteenth channel uses index 10001
// - refresh starts on refresh clock fall
// - switches open on refresh clock rise
// - track while low, hold while high
// - every channel revisited per 18 cycles
// - new code appears within 1..18 cycles; changes over MAX_STEP codes take several visits here
// - consecutive channels on consecutive cycles
// - internal ~21kHz oscillator, may drive pin
// - power-on internal mode, sync pin released
// - select high external, low internal
// - external refresh clock at most 70kHz
// - external clock pulses at least 4us
// - external clock duty above 30%
// - delay rising edge away from loads
// - output moves at most 2V per refresh
// - disable hot, re-enable when cooled
// - shift MSB first on rising sclk
// - update on enable high, ignore sclk
// - serial out after 16 falling edges
// - index plain binary, 0 to 17
`timescale 1ns/100ps
module rdr_device #(
  parameter int OSC_HALF = rdr_pkg::OSC_HALF_CYC,
  parameter int MAX_STEP = rdr_pkg::MAX_STEP_DEFAULT
) (
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  rdr_link_if.dev                          link,
  input  wire logic                        sync_out_en_i,
  input  wire logic                        temp_hot_i,
  input  wire logic                        temp_cool_i,
  output logic      [rdr_pkg::CH_W-1:0]    refresh_ch_o,
  output logic      [rdr_pkg::CODE_W-1:0]  dac_code_o,
  output logic                             track_o,
  output logic                             outputs_en_o,
  output logic                             word_taken_o
);
  localparam int OSC_W = $clog2(OSC_HALF + 1);

  initial begin
    if (OSC_HALF < 1)
      $error("rdr_device: OSC_HALF must be at least one cycle");
  end

  // serial clock domain state
  typedef struct packed {
    logic [rdr_pkg::WORD_W-1:0] shift;
  } rdr_ser_s;

  // system clock domain state
  typedef struct packed {
    logic                                            ena_s1;
    logic                                            ena_s2;
    logic                                            ena_prev;
    logic                                            sel_s1;
    logic                                            sel_s2;
    logic                                            ext_s1;
    logic                                            ext_s2;
    logic                                            hot_s1;
    logic                                            hot_s2;
    logic                                            cool_s1;
    logic                                            cool_s2;
    logic                                            oen_s1;
    logic                                            oen_s2;
    logic [OSC_W-1:0]                                osc_cnt;
    logic                                            osc_lvl;
    logic                                            rclk_prev;
    logic [rdr_pkg::CH_W-1:0]                        ch;
    logic [rdr_pkg::NUM_CH-1:0][rdr_pkg::CODE_W-1:0] target;
    logic [rdr_pkg::NUM_CH-1:0][rdr_pkg::CODE_W-1:0] held;
    logic [rdr_pkg::CODE_W-1:0]                      dac;
    logic                                            track;
    logic                                            out_en;
    logic                                            taken;
    logic                                            sync_o;
    logic                                            sync_oe;
  } rdr_dev_s;

  rdr_ser_s  ser_d, ser_q;
  rdr_dev_s  st_d, st_q;
  logic      sout_q;
  logic [rdr_pkg::CH_W-1:0]   next_ch;
  logic [rdr_pkg::CODE_W-1:0] stepped;
  logic                       rclk;
  logic                       rfall;
  logic                       ext_mode;
  logic [rdr_pkg::CH_W-1:0]   w_idx;
  logic [rdr_pkg::CODE_W-1:0] w_code;

  always_comb begin
    ser_d = ser_q;
    if (!link.frame_enable_n) begin
      ser_d.shift = {ser_q.shift[rdr_pkg::WORD_W-2:0], link.serial_in};
    end
  end

  always_ff @(posedge link.sclk) begin
    ser_q <= ser_d;
  end

  always_ff @(negedge link.sclk) begin
    sout_q <= ser_q.shift[rdr_pkg::WORD_W-1];
  end

  assign link.serial_out  = sout_q;
  assign link.dev_sync_o  = st_q.sync_o;
  assign link.dev_sync_oe = st_q.sync_oe;

  assign next_ch = (st_q.ch == rdr_pkg::LAST_CH) ? rdr_pkg::FIRST_CH
                 : rdr_pkg::CH_W'(st_q.ch + 1'b1);

  assign ext_mode = st_q.sel_s2;
  assign rclk     = ext_mode ? st_q.ext_s2 : st_q.osc_lvl;
  assign rfall    = st_q.rclk_prev & ~rclk;

  // captured word fields, stable while sclk is stopped
  assign w_idx  = rdr_pkg::word_index(ser_q.shift);
  assign w_code = rdr_pkg::word_code(ser_q.shift);

  rdr_step_limiter #(
    .MAX_STEP (MAX_STEP)
  ) u_step (
    .cur_i    (st_q.held[next_ch]),
    .target_i (st_q.target[next_ch]),
    .next_o   (stepped)
  );

  // next-state logic of the refresh side
  always_comb begin
    st_d = st_q;
    // two-stage synchronisers of pins and comparators
    st_d.ena_s1  = link.frame_enable_n;
    st_d.ena_s2  = st_q.ena_s1;
    st_d.sel_s1  = link.clock_source_select;
    st_d.sel_s2  = st_q.sel_s1;
    st_d.ext_s1  = link.sync_clock_pin;
    st_d.ext_s2  = st_q.ext_s1;
    st_d.hot_s1  = temp_hot_i;
    st_d.hot_s2  = st_q.hot_s1;
    st_d.cool_s1 = temp_cool_i;
    st_d.cool_s2 = st_q.cool_s1;
    st_d.oen_s1  = sync_out_en_i;
    st_d.oen_s2  = st_q.oen_s1;
    st_d.ena_prev  = st_q.ena_s2;
    st_d.rclk_prev = rclk;
    st_d.taken     = 1'b0;

    if (st_q.osc_cnt == OSC_W'(OSC_HALF - 1)) begin
      st_d.osc_cnt = '0;
      st_d.osc_lvl = ~st_q.osc_lvl;
    end else begin
      st_d.osc_cnt = OSC_W'(st_q.osc_cnt + 1'b1);
    end
    // pin released until enabled in internal mode
    st_d.sync_o  = st_q.osc_lvl;
    st_d.sync_oe = ~ext_mode & st_q.oen_s2;

    // update addressed channel at frame end
    if (st_q.ena_s2 && !st_q.ena_prev) begin
      if (ser_q.shift[rdr_pkg::CTRL_POS] == rdr_pkg::CTRL_VAL &&
          w_idx <= rdr_pkg::LAST_CH) begin
        st_d.target[w_idx] = w_code;
        st_d.taken         = 1'b1;
      end
    end

    if (rfall) begin
      st_d.ch            = next_ch;
      st_d.held[next_ch] = stepped;
      st_d.dac           = stepped;
    end

    st_d.track = ~rclk & st_q.out_en;

    if (st_q.hot_s2) begin
      st_d.out_en = 1'b0;
    end else if (st_q.cool_s2) begin
      st_d.out_en = 1'b1;
    end
  end

  // refresh side registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q         <= '0;
      st_q.ena_s1  <= 1'b1;
      st_q.ena_s2  <= 1'b1;
      st_q.ena_prev <= 1'b1;
      st_q.ch      <= rdr_pkg::LAST_CH;
      st_q.target  <= {rdr_pkg::NUM_CH{rdr_pkg::CODE_RST}};
      st_q.held    <= {rdr_pkg::NUM_CH{rdr_pkg::CODE_RST}};
      st_q.dac     <= rdr_pkg::CODE_RST;
      st_q.out_en  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state flops
  assign refresh_ch_o = st_q.ch;
  assign dac_code_o   = st_q.dac;
  assign track_o      = st_q.track;
  assign outputs_en_o = st_q.out_en;
  assign word_taken_o = st_q.taken;
endmodule : rdr_device

// ===== rtl/rdr_pkg.sv
/*
 * rdr_pkg: shared constants, word layout, timing counts and types
 * of the reference refresh sequencer and its serial host.
 * Assumes a 40 MHz system clock on both ends.
 */
package rdr_pkg;

  // clock and word geometry
  localparam int CLK_HZ   = 40_000_000;
  localparam int NUM_CH   = 18;
  localparam int CH_W     = 5;
  localparam int CODE_W   = 10;
  localparam int WORD_W   = 16;
  localparam int CODE_STEPS = 1024;

  localparam logic [CH_W-1:0]   FIRST_CH = 5'h00;
  localparam logic [CH_W-1:0]   LAST_CH  = 5'h11;
  localparam logic [CODE_W-1:0] CODE_MAX = 10'h3FF;
  localparam logic [CODE_W-1:0] CODE_MID = 10'h200;
  localparam logic [CODE_W-1:0] CODE_RST = 10'h000;

  // field positions of the programming word
  localparam int   CTRL_POS = 15;
  localparam int   IDX_MSB  = 14;
  localparam int   IDX_LSB  = 10;
  localparam int   CODE_MSB = 9;
  localparam int   CODE_LSB = 0;
  localparam logic CTRL_VAL = 1'b0;

  // round a least time in ns up to whole clk_i cycles, never below one
  function automatic int ns_to_cyc_up(input int ns);
    int c;
    c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc_up

  // internal refresh oscillator
  localparam int OSC_HZ       = 21_000;
  localparam int OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);

  // external refresh clock limits
  localparam int EXT_MAX_HZ         = 70_000;
  localparam int EXT_MIN_PERIOD_CYC = (CLK_HZ + EXT_MAX_HZ - 1) / EXT_MAX_HZ;
  localparam int EXT_MIN_PULSE_NS   = 4000;
  localparam int EXT_MIN_PULSE_CYC  = ns_to_cyc_up(EXT_MIN_PULSE_NS);
  localparam int EXT_MIN_DUTY_PCT   = 30;

  // serial port timing
  localparam int SCLK_MIN_PERIOD_NS = 200;
  localparam int SCLK_HALF_CYC      = ns_to_cyc_up(SCLK_MIN_PERIOD_NS / 2);
  localparam int FE_SETUP_NS        = 10;
  localparam int FE_SETUP_CYC       = ns_to_cyc_up(FE_SETUP_NS);

  // output step limit: 2 V per refresh over the assumed reference span
  localparam int STEP_MV          = 2000;
  localparam int SPAN_MV          = 16000;
  localparam int MAX_STEP_DEFAULT = CODE_STEPS * STEP_MV / SPAN_MV;

  // host serial sequencer states
  typedef enum logic [4:0] {
    RDR_H_IDLE  = 5'b00001,
    RDR_H_SETUP = 5'b00010,
    RDR_H_LOW   = 5'b00100,
    RDR_H_HIGH  = 5'b01000,
    RDR_H_DONE  = 5'b10000
  } rdr_hstate_e;

  // assemble one programming word
  function automatic logic [WORD_W-1:0] build_word(
    input logic [CH_W-1:0]   ch,
    input logic [CODE_W-1:0] code);
    return {CTRL_VAL, ch, code};
  endfunction : build_word

  function automatic logic [CH_W-1:0] word_index(
    input logic [WORD_W-1:0] w);
    return w[IDX_MSB:IDX_LSB];
  endfunction : word_index

  function automatic logic [CODE_W-1:0] word_code(
    input logic [WORD_W-1:0] w);
    return w[CODE_MSB:CODE_LSB];
  endfunction : word_code

endpackage : rdr_pkg

// ===== rtl/rdr_link_if.sv
/*
 * rdr_link_if: three-wire serial port, clock source select and the
 * shared sync clock pin between the host and the sequencer.
 * Assumes the sync pin is weakly pulled low when nobody drives it.
 */
`timescale 1ns/100ps
interface rdr_link_if;
  logic sclk;
  logic frame_enable_n;
  logic serial_in;
  logic serial_out;
  logic clock_source_select;
  logic dev_sync_o;
  logic dev_sync_oe;
  logic host_sync_o;
  logic host_sync_oe;
  logic sync_clock_pin;

  // resolved level of the shared sync pin
  assign sync_clock_pin = dev_sync_oe  ? dev_sync_o  :
                          host_sync_oe ? host_sync_o : 1'b0;

  modport dev (
    input  sclk, frame_enable_n, serial_in, clock_source_select,
    input  sync_clock_pin,
    output serial_out, dev_sync_o, dev_sync_oe
  );

  modport host (
    output sclk, frame_enable_n, serial_in, clock_source_select,
    output host_sync_o, host_sync_oe,
    input  serial_out, sync_clock_pin
  );
endinterface : rdr_link_if

// ===== rtl/rdr_step_limiter.sv
/*
 * rdr_step_limiter: next held code of a channel, moving from the
 * present code toward the target by at most MAX_STEP codes.
 * Assumes codes are unsigned fractions of the reference span.
 */
`timescale 1ns/100ps
module rdr_step_limiter #(
  parameter int MAX_STEP = rdr_pkg::MAX_STEP_DEFAULT
) (
  input  wire logic [rdr_pkg::CODE_W-1:0] cur_i,
  input  wire logic [rdr_pkg::CODE_W-1:0] target_i,
  output logic      [rdr_pkg::CODE_W-1:0] next_o
);
  localparam logic [rdr_pkg::CODE_W-1:0] STEP =
    rdr_pkg::CODE_W'(MAX_STEP);

  initial begin
    if (MAX_STEP < 1 || MAX_STEP > int'(rdr_pkg::CODE_MAX))
      $error("rdr_step_limiter: MAX_STEP out of range");
  end

  always_comb begin
    if (target_i > cur_i) begin
      next_o = (target_i - cur_i > STEP) ? cur_i + STEP : target_i;
    end else begin
      next_o = (cur_i - target_i > STEP) ? cur_i - STEP : target_i;
    end
  end
endmodule : rdr_step_limiter

// ===== rtl/rdr_host.sv
/*
 * rdr_host: host end that sends programming words over the three-wire
 * port and, in external mode, makes the refresh clock on the sync pin.
 * Assumes one request is presented only while busy_o is low.
 */
`timescale 1ns/100ps
module rdr_host #(
  parameter int SCLK_HALF = rdr_pkg::SCLK_HALF_CYC,
  parameter int EXT_LOW   = 300,
  parameter int EXT_HIGH  = 300
) (
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  rdr_link_if.host                        link,
  input  wire logic                       ext_mode_i,
  input  wire logic                       req_i,
  input  wire logic [rdr_pkg::CH_W-1:0]   ch_i,
  input  wire logic [rdr_pkg::CODE_W-1:0] code_i,
  output logic                            busy_o
);
  localparam int HW = $clog2(SCLK_HALF + 1);
  localparam int EW = $clog2(EXT_LOW + EXT_HIGH + 1);
  localparam int BW = $clog2(rdr_pkg::WORD_W);

  initial begin
    if (SCLK_HALF < rdr_pkg::SCLK_HALF_CYC)
      $error("rdr_host: serial clock too fast");
    if (EXT_LOW + EXT_HIGH < rdr_pkg::EXT_MIN_PERIOD_CYC)
      $error("rdr_host: external refresh clock too fast");
    if (EXT_LOW < rdr_pkg::EXT_MIN_PULSE_CYC ||
        EXT_HIGH < rdr_pkg::EXT_MIN_PULSE_CYC)
      $error("rdr_host: external refresh pulse too short");
    if (EXT_HIGH * 100 <= rdr_pkg::EXT_MIN_DUTY_PCT * (EXT_LOW + EXT_HIGH))
      $error("rdr_host: external refresh duty too low");
  end

  typedef struct packed {
    rdr_pkg::rdr_hstate_e       st;
    logic [HW-1:0]              cnt;
    logic [BW-1:0]              bitn;
    logic [rdr_pkg::WORD_W-1:0] word;
    logic                       sclk;
    logic                       en_n;
    logic                       sdat;
    logic                       busy;
    logic                       sel;
    logic [EW-1:0]              ecnt;
    logic                       elvl;
  } rdr_host_s;

  rdr_host_s h_d, h_q;
  logic      half_done;

  assign half_done = (h_q.cnt == HW'(SCLK_HALF - 1));

  // serial sequencer and external clock generator
  always_comb begin
    h_d     = h_q;
    h_d.cnt = half_done ? '0 : HW'(h_q.cnt + 1'b1);
    h_d.sel = ext_mode_i;
    // low phase sets rising edge delay
    if (h_q.ecnt == EW'(EXT_LOW + EXT_HIGH - 1)) begin
      h_d.ecnt = '0;
      h_d.elvl = 1'b0;
    end else begin
      h_d.ecnt = EW'(h_q.ecnt + 1'b1);
      if (h_q.ecnt == EW'(EXT_LOW - 1)) h_d.elvl = 1'b1;
    end
    case (h_q.st)
      rdr_pkg::RDR_H_IDLE: begin
        h_d.cnt = '0;
        if (req_i) begin
          h_d.word = rdr_pkg::build_word(ch_i, code_i);
          h_d.bitn = BW'(rdr_pkg::WORD_W - 1);
          h_d.en_n = 1'b0;
          h_d.busy = 1'b1;
          h_d.st   = rdr_pkg::RDR_H_SETUP;
        end
      end
      rdr_pkg::RDR_H_SETUP: begin
        if (half_done) begin
          h_d.sdat = h_q.word[h_q.bitn];
          h_d.st  = rdr_pkg::RDR_H_LOW;
        end
      end
      rdr_pkg::RDR_H_LOW: begin
        if (half_done) begin
          h_d.sclk = 1'b1;
          h_d.st   = rdr_pkg::RDR_H_HIGH;
        end
      end
      rdr_pkg::RDR_H_HIGH: begin
        if (half_done) begin
          h_d.sclk = 1'b0;
          if (h_q.bitn == '0) begin
            h_d.st = rdr_pkg::RDR_H_DONE;
          end else begin
            h_d.bitn = BW'(h_q.bitn - 1'b1);
            h_d.sdat = h_q.word[h_q.bitn - 1'b1];
            h_d.st   = rdr_pkg::RDR_H_LOW;
          end
        end
      end
      rdr_pkg::RDR_H_DONE: begin
        if (half_done) begin
          if (!h_q.en_n) begin
            h_d.en_n = 1'b1;
          end else begin
            h_d.busy = 1'b0;
            h_d.st   = rdr_pkg::RDR_H_IDLE;
          end
        end
      end
      default: h_d.st = rdr_pkg::RDR_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      h_q      <= '0;
      h_q.st   <= rdr_pkg::RDR_H_IDLE;
      h_q.en_n <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  assign link.sclk                = h_q.sclk;
  assign link.frame_enable_n      = h_q.en_n;
  assign link.serial_in           = h_q.sdat;
  assign link.clock_source_select = h_q.sel;
  assign link.host_sync_o         = h_q.elvl;
  assign link.host_sync_oe        = h_q.sel;
  assign busy_o                   = h_q.busy;
endmodule : rdr_host

// ===== dv/rdr_link_monitor.sv
/* rdr_link_monitor: concurrent checks on the serial link, sync pin
   and sequencer outputs. Assumes one clk_i domain, sync reset. */
`timescale 1ns/100ps
module rdr_link_monitor (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       sclk,
  input wire logic       frame_enable_n,
  input wire logic       serial_in,
  input wire logic       clock_source_select,
  input wire logic       dev_sync_oe,
  input wire logic       sync_clock_pin,
  input wire logic [4:0] refresh_ch_o,
  input wire logic       track_o,
  input wire logic       outputs_en_o,
  input wire logic       word_taken_o,
  input wire logic       temp_hot_i,
  input wire logic       temp_cool_i
);
  typedef struct packed {
    logic        sclk;
    logic        fe;
    logic [4:0]  cnt;
    logic [15:0] word;
  } rdr_mon_s;
  rdr_mon_s mon_q, mon_d;
  logic     idx_ok;
  // frame bit count and captured word
  always_comb begin
    mon_d      = mon_q;
    mon_d.sclk = sclk;
    mon_d.fe   = frame_enable_n;
    if (frame_enable_n && mon_q.fe) begin
      mon_d.cnt  = 5'h00;
      mon_d.word = 16'h0000;
    end else if (!frame_enable_n && sclk && !mon_q.sclk) begin
      mon_d.cnt  = mon_q.cnt + 5'h01;
      mon_d.word = {mon_q.word[14:0], serial_in};
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) mon_q <= '0;
    else mon_q <= mon_d;
  end
  assign idx_ok = !mon_q.word[15] && mon_q.word[14:10] <= rdr_pkg::LAST_CH;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_frame_end; $rose(frame_enable_n); endsequence
  sequence s_ext_fall; clock_source_select [*8] ##0 $fell(sync_clock_pin);
  endsequence
  property p_ctrl_zero;
    !frame_enable_n && sclk && !mon_q.sclk && mon_q.cnt == 5'h00
      |-> !serial_in;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("lead bit set");
  property p_word_len; s_frame_end |-> mon_q.cnt == 5'h10; endproperty
  a_word_len: assert property (p_word_len) else $error("frame not 16");
  property p_sclk_idle; frame_enable_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk idle");
  property p_taken; s_frame_end ##0 idx_ok |-> ##[2:6] word_taken_o;
  endproperty
  a_taken: assert property (p_taken) else $error("word not taken");
  property p_refuse; s_frame_end ##0 !idx_ok |-> !word_taken_o [*6];
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad index taken");
  property p_ch_next;
    $changed(refresh_ch_o) |-> refresh_ch_o ==
      (($past(refresh_ch_o) == rdr_pkg::LAST_CH) ? rdr_pkg::FIRST_CH :
       $past(refresh_ch_o) + 5'h01);
  endproperty
  a_ch_next: assert property (p_ch_next) else $error("refresh order");
  property p_ext_fall; s_ext_fall |-> ##[2:6] $changed(refresh_ch_o);
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("no refresh");
  property p_ext_hold;
    (clock_source_select && sync_clock_pin) [*8] |-> !track_o;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("not held");
  property p_ext_track;
    (clock_source_select && !sync_clock_pin && outputs_en_o) [*8] |-> track_o;
  endproperty
  a_ext_track: assert property (p_ext_track) else $error("not track");
  property p_hot; temp_hot_i [*8] |-> !outputs_en_o; endproperty
  a_hot: assert property (p_hot) else $error("hot but enabled");
  property p_cool; (temp_cool_i && !temp_hot_i) [*8] |-> outputs_en_o;
  endproperty
  a_cool: assert property (p_cool) else $error("cool but off");
  property p_boot; $fell(sys_rst_i) |-> !dev_sync_oe; endproperty
  a_boot: assert property (p_boot) else $error("pin driven at boot");
endmodule : rdr_link_monitor

// ===== dv/tb.sv
/* tb: host and sequencer joined by the link, scoreboarded outputs.
   Assumes a 40 MHz clk_i and the sequencer's fast oscillator. */
`timescale 1ns/100ps
module tb;
  localparam int STEP = rdr_pkg::MAX_STEP_DEFAULT;
  localparam logic [15:0] WTAB[8] = '{16'h0000, 16'h03FF, 16'h0200,
    16'h0A01, 16'h1C1F, 16'h441F, 16'h4A00, 16'h7FFF};
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, ext_mode_i = 1'b0;
  logic        req_i = 1'b0, sync_out_en_i = 1'b0;
  logic        temp_hot_i = 1'b0, temp_cool_i = 1'b0;
  logic [4:0]  ch_i = 5'h00, refresh_ch_o, ch_q = 5'h11, nx;
  logic [9:0]  code_i = 10'h000, dac_code_o, ex, alt;
  logic        track_o, outputs_en_o, word_taken_o, busy_o, seen;
  logic        sclk_q = 1'b0, fe_q = 1'b1;
  logic [15:0] wire_w = 16'h0000, prev_w;
  logic [16:0] notes[$], cur;
  logic [9:0]  tgt[18], held[18], old_t[18];
  int          age[18], bad_count = 0, checks = 0, cyc = 0;
  int          nbit = 0, nfr = 0, win = 0;
  always #12.5 clk_i = ~clk_i;
  rdr_link_if link();
  rdr_device #(.OSC_HALF(8), .MAX_STEP(STEP)) i_rdr_device (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link),
    .sync_out_en_i(sync_out_en_i), .temp_hot_i(temp_hot_i),
    .temp_cool_i(temp_cool_i), .refresh_ch_o(refresh_ch_o),
    .dac_code_o(dac_code_o), .track_o(track_o),
    .outputs_en_o(outputs_en_o), .word_taken_o(word_taken_o));
  rdr_host #(.SCLK_HALF(4), .EXT_LOW(300), .EXT_HIGH(300)) i_rdr_host (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link),
    .ext_mode_i(ext_mode_i), .req_i(req_i), .ch_i(ch_i),
    .code_i(code_i), .busy_o(busy_o));
  rdr_link_monitor i_rdr_link_monitor (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk(link.sclk),
    .frame_enable_n(link.frame_enable_n), .serial_in(link.serial_in),
    .clock_source_select(link.clock_source_select),
    .dev_sync_oe(link.dev_sync_oe), .sync_clock_pin(link.sync_clock_pin),
    .refresh_ch_o(refresh_ch_o), .track_o(track_o),
    .outputs_en_o(outputs_en_o), .word_taken_o(word_taken_o),
    .temp_hot_i(temp_hot_i), .temp_cool_i(temp_cool_i));

  task automatic chk(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [9:0] stepf(input logic [9:0] h, t);
    if (int'(t) > int'(h) + STEP) return h + 10'(STEP);
    if (int'(h) > int'(t) + STEP) return h - 10'(STEP);
    return t;
  endfunction : stepf

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // one word request, expectation noted first
  task automatic send(input logic [4:0] c, input logic [9:0] d);
    while (busy_o !== 1'b0) @(posedge clk_i);
    notes.push_back({c <= 5'h11, 1'b0, c, d});
    req_i  <= 1'b1;
    ch_i   <= c;
    code_i <= d;
    @(posedge clk_i);
    req_i <= 1'b0;
    @(posedge clk_i);
    chk("busy", 16'h0001, 16'(busy_o));
  endtask : send

  // watcher: wire words, taken pulses, refresh model, timeout
  always @(posedge clk_i) begin
    cyc++;
    if (!link.frame_enable_n && link.sclk && !sclk_q) begin
      if (nfr > 0) chk("serial_out", prev_w[15-nbit], link.serial_out);
      wire_w = {wire_w[14:0], link.serial_in};
      nbit++;
    end
    if (link.frame_enable_n && !fe_q) begin
      cur = notes.pop_front();
      chk("wire word", cur[15:0], wire_w);
      prev_w = wire_w;
      nfr++;
      nbit = 0;
      win  = 8;
      seen = 1'b0;
    end
    foreach (age[i]) age[i]++;
    if (win > 0) begin
      if (word_taken_o === 1'b1 && !seen) begin
        seen = 1'b1;
        old_t[cur[14:10]] = tgt[cur[14:10]];
        tgt[cur[14:10]] = cur[9:0];
        age[cur[14:10]] = 0;
      end
      win--;
      if (win == 0) chk("word taken", 16'(cur[16]), 16'(seen));
    end
    if (!sys_rst_i && refresh_ch_o !== ch_q) begin
      nx = (ch_q == 5'h11) ? 5'h00 : ch_q + 5'h01;
      chk("refresh channel", 16'(nx), 16'(refresh_ch_o));
      ex  = stepf(held[nx], tgt[nx]);
      alt = stepf(held[nx], old_t[nx]);
      if (age[nx] < 6 && dac_code_o === alt) ex = alt;
      chk("dac code", 16'(ex), 16'(dac_code_o));
      held[nx] = ex;
      ch_q = refresh_ch_o;
    end
    sclk_q = link.sclk;
    fe_q   = link.frame_enable_n;
    if (cyc > 30000) begin
      bad_count++;
      end_of_test();
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'hEC9C));
    foreach (tgt[i]) begin
      tgt[i] = 10'h000;
      held[i] = 10'h000;
      old_t[i] = 10'h000;
      age[i] = 99;
    end
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("sync drive", 16'h0000, 16'(link.dev_sync_oe));
    chk("outputs on", 16'h0001, 16'(outputs_en_o));
    sync_out_en_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("sync drive", 16'h0001, 16'(link.dev_sync_oe));
    foreach (WTAB[i]) send(WTAB[i][14:10], WTAB[i][9:0]);
    repeat (6) send(5'($urandom_range(17, 0)), 10'($urandom_range(1023, 0)));
    repeat (2700) @(posedge clk_i);
    ext_mode_i <= 1'b1;
    send(5'($urandom_range(17, 0)), 10'($urandom_range(1023, 0)));
    chk("select", 16'h0001, 16'(link.clock_source_select));
    repeat (9000) @(posedge clk_i);
    ext_mode_i <= 1'b0;
    repeat (2700) @(posedge clk_i);
    temp_hot_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("outputs on", 16'h0000, 16'(outputs_en_o));
    temp_cool_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("outputs on", 16'h0000, 16'(outputs_en_o));
    temp_hot_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("outputs on", 16'h0001, 16'(outputs_en_o));
    end_of_test();
  end
endmodule : tb
